// ==== verilog/ctl_port_pkg.sv ====
// constants and types shared by the control port modules
package ctl_port_pkg;
	// serial pin indices inside the synchroniser bundle
	localparam int PIN_CLK = 0;
	localparam int PIN_DAT = 1;
	localparam int PIN_SEL = 2;
	localparam int PIN_COUNT = 3;

	// chip addresses
	localparam logic [5:0] I2C_ADDR_UPPER = 6'h0c;
	localparam logic [6:0] SPI_ADDR = 7'h18;
	localparam logic RW_WRITE = 1'b0;

	// byte and pointer layout
	localparam int BYTE_W = 8;
	localparam int PTR_W = 5;
	localparam int AUTOINC_BIT = 7;
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] SPI_LAST_BIT = 4'h7;
	localparam logic [PTR_W-1:0] PTR_RESET = 5'h00;
	localparam logic AUTOINC_RESET = 1'b0;
	localparam logic [PTR_W-1:0] BANK_A_FIRST = 5'h01;
	localparam logic [PTR_W-1:0] BANK_A_LAST = 5'h08;
	localparam logic [PTR_W-1:0] BANK_B_LAST = 5'h11;
	localparam logic [PTR_W-1:0] PTR_STEP = 5'h01;

	// location of the port enable bit in the settings map
	localparam logic [PTR_W-1:0] PORT_EN_ADDR = 5'h02;
	localparam int PORT_EN_BIT = 1;

	// byte phase within one transfer: chip address, pointer, then data
	localparam logic [1:0] PH_ADDR = 2'h0;
	localparam logic [1:0] PH_PTR = 2'h1;
	localparam logic [1:0] PH_DATA = 2'h2;
	localparam logic [1:0] PH_STEP = 2'h1;
	localparam logic [3:0] BIT_STEP = 4'h1;

	// transfer states
	typedef enum logic [2:0] {
		S_IDLE,
		S_RX,
		S_ACK,
		S_READ,
		S_RACK,
		S_SPI
	} xfer_e;
endpackage

// ==== verilog/pin_sync_if.sv ====
// synchronised serial pin levels and edges passed to the port logic
`timescale 1ns/100ps
interface pin_sync_if #(parameter int WIDTH = 3);
	logic [WIDTH-1:0] lvl;
	logic [WIDTH-1:0] rise;
	logic [WIDTH-1:0] fall;

	modport src (output lvl, output rise, output fall);
	modport dst (input lvl, input rise, input fall);
endinterface

// ==== verilog/pin_sync.sv ====
// two-flop synchroniser with edge detection for the serial pins
`timescale 1ns/100ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// raw pins
	input wire logic [WIDTH-1:0] pins_i,
	// synchronised view
	pin_sync_if.src sync
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
	} sync_s;

	sync_s st;
	sync_s next_st;

	// stage one feeds only stage two; edges come from stages two and three
	always_comb begin
		next_st.s1 = pins_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
	end

	// idle bus levels are high, so reset to ones to avoid false edges
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st <= '1;
		end else begin
			st <= next_st;
		end
	end

	assign sync.lvl = st.s2;
	assign sync.rise = st.s2 & ~st.s3;
	assign sync.fall = ~st.s2 & st.s3;
endmodule

// ==== verilog/dual_format_control_port.sv ====
// control port target: two-wire and write-only three-wire serial access to settings
// Summary of operation
// R1 - host sets the port enable bit by a write in either format
// R2 - with port enabled the shared pins serve only the control port
// R3 - enabling the port halts pin power-up and restores default settings
// R4 - host should enable the port before about 1024 frame clocks
// R5 - port enable write accepted any time after reset release
// R6 - device is only ever a target, never starts a transfer
// R7 - falling select edge chooses three-wire format, else two-wire stays
// R8 - receiver of each byte acknowledges it on the two-wire bus
// R9 - two-wire address is 001100 plus the address pin level
// R10 - host keeps the master clock running during two-wire transfers
// R11 - write is start, address, pointer, data bytes, then stop
// R12 - host waits for device acknowledge between written bytes
// R13 - read returns register at pointer right after the address byte
// R14 - host acknowledges each read byte and ends with stop
// R15 - three-wire pins are inputs, data sampled on rising bit clock
// R16 - three-wire format is write only
// R17 - three-wire write: select low, address 0011000, write bit, pointer, data
// R18 - host holds select low for more bytes, raises it to end
// R19 - pointer byte bit 7 enables auto-increment, default off
// R20 - auto-increment runs within 01h-08h and 09h-11h, never 08h to 09h
// R21 - pointer is five low bits of pointer byte, reset to zero
// R22 - without auto-increment the pointer holds across data bytes
// R23 - port works with no timing tie to audio sample clocks
// R24 - reset held low keeps all port settings at defaults
// R25 - serial pins synchronised, edges and start/stop found from samples
// R26 - mismatched chip address is neither acknowledged nor acted on
`timescale 1ns/100ps
module dual_format_control_port (
	// clock and reset
	input wire logic REF_CLK_I,
	input wire logic RST_N_I,
	// serial pins: bit clock, data (open drain in two-wire), address or select
	input wire logic CTRL_BIT_CLK_I,
	input wire logic SERIAL_DATA_I,
	output logic SERIAL_DATA_O,
	output logic SERIAL_DATA_OE_N_O,
	input wire logic ADDR_OR_SELECT_I,
	// settings map access
	output logic [ctl_port_pkg::PTR_W-1:0] REG_ADDR_O,
	output logic REG_WR_O,
	output logic [ctl_port_pkg::BYTE_W-1:0] REG_WDATA_O,
	input wire logic [ctl_port_pkg::BYTE_W-1:0] REG_RDATA_I,
	// mode status
	output logic PORT_EN_O,
	output logic LOAD_DEFAULTS_O,
	output logic CFG_PINS_LIVE_O,
	output logic SPI_MODE_O
);
	typedef struct packed {
		ctl_port_pkg::xfer_e fsm;
		logic spi_mode;
		logic port_en;
		logic cfg_pins;
		logic defaults;
		logic [3:0] bits;
		logic [1:0] phase;
		logic rw;
		logic [ctl_port_pkg::BYTE_W-1:0] shreg;
		logic [ctl_port_pkg::PTR_W-1:0] ptr;
		logic autoinc;
		logic sda_o;
		logic sda_oe_n;
		logic wr;
		logic [ctl_port_pkg::PTR_W-1:0] waddr;
		logic [ctl_port_pkg::BYTE_W-1:0] wdata;
	} port_s;

	port_s st;
	port_s next_st;

	// synchronised pins; all control logic runs on the reference clock [R23]
	pin_sync_if #(.WIDTH(ctl_port_pkg::PIN_COUNT)) pins ();

	pin_sync #(.WIDTH(ctl_port_pkg::PIN_COUNT)) u_sync (
		.clk_i(REF_CLK_I),
		.rst_n_i(RST_N_I),
		.pins_i({ADDR_OR_SELECT_I, SERIAL_DATA_I, CTRL_BIT_CLK_I}),
		.sync(pins)
	); // [R25]

	logic clk_lvl;
	logic clk_rise;
	logic clk_fall;
	logic dat_lvl;
	logic dat_rise;
	logic dat_fall;
	logic sel_lvl;
	logic sel_fall;
	logic i2c_start;
	logic i2c_stop;

	// start and stop are data edges while the bit clock is high [R25]
	assign clk_lvl = pins.lvl[ctl_port_pkg::PIN_CLK];
	assign clk_rise = pins.rise[ctl_port_pkg::PIN_CLK];
	assign clk_fall = pins.fall[ctl_port_pkg::PIN_CLK];
	assign dat_lvl = pins.lvl[ctl_port_pkg::PIN_DAT];
	assign dat_rise = pins.rise[ctl_port_pkg::PIN_DAT];
	assign dat_fall = pins.fall[ctl_port_pkg::PIN_DAT];
	assign sel_lvl = pins.lvl[ctl_port_pkg::PIN_SEL];
	assign sel_fall = pins.fall[ctl_port_pkg::PIN_SEL];
	assign i2c_start = dat_fall && clk_lvl;
	assign i2c_stop = dat_rise && clk_lvl;

	// next pointer: stays put without auto-increment, stops at bank ends
	function automatic logic [ctl_port_pkg::PTR_W-1:0] step_ptr(
		input logic [ctl_port_pkg::PTR_W-1:0] p,
		input logic inc
	);
		logic [ctl_port_pkg::PTR_W-1:0] r;
		r = p;
		if (inc && p != ctl_port_pkg::BANK_A_LAST && p != ctl_port_pkg::BANK_B_LAST) begin
			r = p + ctl_port_pkg::PTR_STEP; // [R20]
		end
		return r; // [R22]
	endfunction

	// transfer engine for both formats; a byte from either ends up in one handler
	always_comb begin
		logic got_byte;
		logic [ctl_port_pkg::BYTE_W-1:0] val;
		logic accept;
		got_byte = 1'b0;
		val = st.shreg;
		accept = 1'b0;
		next_st = st;
		next_st.wr = 1'b0;
		next_st.defaults = 1'b0;

		if (sel_fall) begin
			// a select edge can only come from a three-wire host [R7]
			next_st.spi_mode = 1'b1;
			next_st.fsm = ctl_port_pkg::S_SPI;
			next_st.bits = '0;
			next_st.phase = ctl_port_pkg::PH_ADDR;
			next_st.sda_oe_n = 1'b1;
		end else if (st.spi_mode) begin
			// three-wire: every pin is an input, data never driven [R15] [R16]
			next_st.sda_oe_n = 1'b1;
			if (sel_lvl) begin
				next_st.fsm = ctl_port_pkg::S_IDLE; // [R18]
			end else if (clk_rise && st.fsm == ctl_port_pkg::S_SPI) begin
				val = {st.shreg[ctl_port_pkg::BYTE_W-2:0], dat_lvl}; // [R15]
				next_st.shreg = val;
				next_st.bits = st.bits + ctl_port_pkg::BIT_STEP;
				if (st.bits == ctl_port_pkg::SPI_LAST_BIT) begin
					got_byte = 1'b1;
					next_st.bits = '0;
				end
			end
		end else if (i2c_start) begin
			next_st.fsm = ctl_port_pkg::S_RX; // [R11]
			next_st.bits = '0;
			next_st.phase = ctl_port_pkg::PH_ADDR;
			next_st.sda_oe_n = 1'b1;
		end else if (i2c_stop) begin
			next_st.fsm = ctl_port_pkg::S_IDLE; // [R14]
			next_st.sda_oe_n = 1'b1;
		end else begin
			case (st.fsm)
				ctl_port_pkg::S_RX: begin
					if (clk_rise) begin
						next_st.shreg = {st.shreg[ctl_port_pkg::BYTE_W-2:0], dat_lvl};
						next_st.bits = st.bits + ctl_port_pkg::BIT_STEP;
					end else if (clk_fall && st.bits == ctl_port_pkg::BITS_PER_BYTE) begin
						got_byte = 1'b1;
						next_st.bits = '0;
					end
				end
				ctl_port_pkg::S_ACK: begin
					// ack is held from one falling edge to the next [R8]
					if (clk_fall) begin
						next_st.sda_oe_n = 1'b1;
						next_st.fsm = ctl_port_pkg::S_RX;
						next_st.bits = '0;
						if (st.rw != ctl_port_pkg::RW_WRITE && st.phase == ctl_port_pkg::PH_PTR) begin
							// read starts at the current pointer [R13]
							next_st.shreg = {REG_RDATA_I[ctl_port_pkg::BYTE_W-2:0], 1'b0};
							next_st.sda_oe_n = REG_RDATA_I[ctl_port_pkg::BYTE_W-1];
							next_st.bits = ctl_port_pkg::BIT_STEP;
							next_st.fsm = ctl_port_pkg::S_READ;
						end
					end
				end
				ctl_port_pkg::S_READ: begin
					// open drain: release for ones, pull low for zeros
					if (clk_fall) begin
						if (st.bits == ctl_port_pkg::BITS_PER_BYTE) begin
							next_st.sda_oe_n = 1'b1;
							next_st.bits = '0;
							next_st.fsm = ctl_port_pkg::S_RACK;
						end else begin
							next_st.sda_oe_n = st.shreg[ctl_port_pkg::BYTE_W-1];
							next_st.shreg = {st.shreg[ctl_port_pkg::BYTE_W-2:0], 1'b0};
							next_st.bits = st.bits + ctl_port_pkg::BIT_STEP;
						end
					end
				end
				ctl_port_pkg::S_RACK: begin
					// pointer moves on the host ack so read data is settled by the fall [R14]
					if (clk_rise) begin
						if (dat_lvl) begin
							next_st.fsm = ctl_port_pkg::S_IDLE;
						end else begin
							next_st.ptr = step_ptr(st.ptr, st.autoinc); // [R20] [R22]
							next_st.bits = ctl_port_pkg::BIT_STEP;
						end
					end else if (clk_fall && st.bits == ctl_port_pkg::BIT_STEP) begin
						next_st.shreg = {REG_RDATA_I[ctl_port_pkg::BYTE_W-2:0], 1'b0};
						next_st.sda_oe_n = REG_RDATA_I[ctl_port_pkg::BYTE_W-1];
						next_st.fsm = ctl_port_pkg::S_READ;
					end
				end
				default: begin
					// idle or ignored transfer: stay off the bus until start [R6] [R26]
					next_st.sda_oe_n = 1'b1;
				end
			endcase
		end

		// one handler for every completed byte of either format
		if (got_byte) begin
			accept = 1'b1;
			if (st.phase == ctl_port_pkg::PH_ADDR) begin
				next_st.rw = val[0];
				if (st.spi_mode) begin
					accept = val[ctl_port_pkg::BYTE_W-1:1] == ctl_port_pkg::SPI_ADDR
						&& val[0] == ctl_port_pkg::RW_WRITE; // [R17] [R16]
				end else begin
					accept = val[ctl_port_pkg::BYTE_W-1:1] == {ctl_port_pkg::I2C_ADDR_UPPER, sel_lvl}; // [R9]
				end
			end else if (st.phase == ctl_port_pkg::PH_PTR) begin
				next_st.ptr = val[ctl_port_pkg::PTR_W-1:0]; // [R21]
				next_st.autoinc = val[ctl_port_pkg::AUTOINC_BIT]; // [R19]
			end else begin
				next_st.wr = 1'b1; // [R11] [R17]
				next_st.waddr = st.ptr;
				next_st.wdata = val;
				next_st.ptr = step_ptr(st.ptr, st.autoinc); // [R20] [R22]
				if (st.ptr == ctl_port_pkg::PORT_EN_ADDR) begin
					// accepted whenever out of reset, any enable while disabled restores defaults [R5] [R3]
					next_st.port_en = val[ctl_port_pkg::PORT_EN_BIT];
					next_st.cfg_pins = !val[ctl_port_pkg::PORT_EN_BIT]; // [R2]
					next_st.defaults = val[ctl_port_pkg::PORT_EN_BIT] && !st.port_en; // [R3]
				end
			end
			if (st.phase != ctl_port_pkg::PH_DATA) begin
				next_st.phase = st.phase + ctl_port_pkg::PH_STEP;
			end
			if (!accept) begin
				next_st.fsm = ctl_port_pkg::S_IDLE; // [R26]
			end else if (!st.spi_mode) begin
				next_st.sda_oe_n = 1'b0; // [R8]
				next_st.fsm = ctl_port_pkg::S_ACK;
			end
		end
	end

	// synchronous reset puts every setting back to its default [R24]
	always_ff @(posedge REF_CLK_I) begin
		if (!RST_N_I) begin
			st <= '0;
			st.fsm <= ctl_port_pkg::S_IDLE;
			st.ptr <= ctl_port_pkg::PTR_RESET;
			st.autoinc <= ctl_port_pkg::AUTOINC_RESET;
			st.sda_oe_n <= 1'b1;
			st.cfg_pins <= 1'b1;
		end else begin
			st <= next_st;
		end
	end

	// all outputs straight from the state register
	assign SERIAL_DATA_O = st.sda_o;
	assign SERIAL_DATA_OE_N_O = st.sda_oe_n;
	assign REG_ADDR_O = st.ptr;
	assign REG_WR_O = st.wr;
	assign REG_WDATA_O = st.wdata;
	assign PORT_EN_O = st.port_en;
	assign LOAD_DEFAULTS_O = st.defaults;
	assign CFG_PINS_LIVE_O = st.cfg_pins;
	assign SPI_MODE_O = st.spi_mode;

	// checks on the port behaviour
	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (!RST_N_I);

	chk_spi_no_drive: assert property (st.spi_mode |-> st.sda_oe_n) // [R16]
		else $error("data pin driven in three-wire format");
	chk_idle_no_drive: assert property (st.fsm == ctl_port_pkg::S_IDLE |=> st.sda_oe_n || st.fsm != ctl_port_pkg::S_IDLE) // [R6]
		else $error("data pin driven while idle");
	chk_select_picks_spi: assert property (sel_fall |=> st.spi_mode && st.fsm == ctl_port_pkg::S_SPI) // [R7]
		else $error("select edge did not choose three-wire format");
	chk_pins_dedicated: assert property (st.port_en |-> !st.cfg_pins) // [R2]
		else $error("shared pins live while port enabled");
	chk_enable_defaults: assert property ($rose(st.port_en) |-> st.defaults && $past(st.wr) == 1'b0 && st.wr) // [R3]
		else $error("port enable without default restore");
	chk_write_pulse: assert property (st.wr |=> !st.wr) // [R11]
		else $error("write strobe longer than one cycle");
	chk_ptr_hold: assert property (st.wr && !st.autoinc |-> st.ptr == st.waddr) // [R22]
		else $error("pointer moved without auto-increment");
	chk_no_bank_cross: assert property (st.wr && st.waddr == ctl_port_pkg::BANK_A_LAST |-> st.ptr == ctl_port_pkg::BANK_A_LAST) // [R20]
		else $error("pointer crossed from first bank to second");
	chk_ptr_advance: assert property (st.wr && st.autoinc && st.waddr >= ctl_port_pkg::BANK_A_FIRST
		&& st.waddr < ctl_port_pkg::BANK_A_LAST |-> st.ptr == st.waddr + ctl_port_pkg::PTR_STEP) // [R20]
		else $error("pointer did not advance");
	chk_ack_after_byte: assert property (st.fsm == ctl_port_pkg::S_RX && clk_fall && st.bits == ctl_port_pkg::BITS_PER_BYTE
		&& st.phase != ctl_port_pkg::PH_ADDR && !i2c_start && !i2c_stop && !sel_fall && !st.spi_mode
		|=> !st.sda_oe_n ##1 !st.sda_oe_n) // [R8]
		else $error("received byte not acknowledged");
	// the default disable would switch this check off exactly while reset is low, so it is overridden here
	chk_reset_defaults: assert property (@(posedge REF_CLK_I) disable iff (1'b0) !RST_N_I |=> !st.port_en && st.ptr == ctl_port_pkg::PTR_RESET
		&& !st.autoinc) // [R24]
		else $error("settings not at defaults after reset");

	cov_spi_write: cover property (st.spi_mode && st.wr);
	cov_i2c_write: cover property (!st.spi_mode && st.wr);
	cov_i2c_read: cover property (st.fsm == ctl_port_pkg::S_RACK ##1 st.fsm == ctl_port_pkg::S_RACK);
	cov_port_enable: cover property ($rose(st.port_en));
endmodule

// ==== testbench/host_master_model.sv ====
// host side model: two-wire and three-wire master on the control port pins
`timescale 1ns/100ps
module host_master_model (
	// pacing clock
	input wire logic clk_i,
	// device side of the shared data pin
	input wire logic data_i,
	input wire logic data_oe_n_i,
	// pins towards the device
	output logic bit_clk_o,
	output logic data_line_o,
	output logic select_n_o
);
	logic drv;
	// open-drain wire: pulled up unless a party pulls it low
	assign data_line_o = drv & (data_oe_n_i | data_i);
	initial begin
		drv = 1'b1;
		bit_clk_o = 1'b1;
		select_n_o = 1'b1; // static while in two-wire use
	end
	// a quarter of the 800 ns bit period
	task automatic q();
		repeat (2) @(posedge clk_i);
	endtask
	// start or repeated start, extra settle so a pending ack is released first
	task automatic start();
		drv <= 1'b1;
		q();
		q();
		bit_clk_o <= 1'b1;
		q();
		drv <= 1'b0;
		q();
		bit_clk_o <= 1'b0;
		q();
	endtask
	task automatic stop();
		drv <= 1'b0;
		q();
		bit_clk_o <= 1'b1;
		q();
		drv <= 1'b1;
		q();
	endtask
	// one bit: data set mid low phase, wire sampled late in the high phase
	task automatic bit_io(input logic b, output logic r);
		drv <= b;
		q();
		bit_clk_o <= 1'b1;
		q();
		q();
		r = data_line_o;
		bit_clk_o <= 1'b0;
		q();
	endtask
	// eight bits msb first, then the acknowledge slot
	task automatic xfer_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] r, output logic ack);
		logic t;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], t);
			r[i] = t;
		end
		bit_io(ack_in, ack);
	endtask
	task automatic spi_begin();
		select_n_o <= 1'b0;
		q();
		q();
	endtask
	// data changes while the bit clock is low, device samples on the rise
	task automatic spi_byte(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			bit_clk_o <= 1'b0;
			drv <= d[i];
			q();
			q();
			bit_clk_o <= 1'b1;
			q();
			q();
		end
	endtask
	// released data line shows the inverse so a stale level is never trusted
	task automatic spi_end();
		select_n_o <= 1'b1;
		drv <= ~drv;
		q();
		q();
	endtask
endmodule

// ==== testbench/tb_dual_format_control_port.sv ====
// self-checking bench for the dual format control port
`timescale 1ns/100ps
module tb_dual_format_control_port;
	localparam logic [7:0] dev_wr = {ctl_port_pkg::I2C_ADDR_UPPER, 1'b1, ctl_port_pkg::RW_WRITE};
	localparam logic [7:0] dev_rd = dev_wr | 8'h01;
	localparam logic [7:0] spi_hdr = {ctl_port_pkg::SPI_ADDR, ctl_port_pkg::RW_WRITE};
	logic ref_clk;
	logic rst_n;
	logic bit_clk;
	logic data_line;
	logic select_n;
	logic data_o;
	logic data_oe_n;
	logic [4:0] reg_addr;
	logic [4:0] prev_addr;
	logic reg_wr;
	logic [7:0] reg_wdata;
	logic [7:0] reg_rdata;
	logic port_en;
	logic load_def;
	logic cfg_live;
	logic spi_mode;
	logic [7:0] mem [32];
	logic [7:0] wq [$];
	logic [7:0] rd;
	logic ack;
	int num_errors = 0;
	int checked = 0;
	int wr_cnt = 0;
	int load_cnt = 0;
	int spi_drv = 0;
	// master clock keeps running through every transfer
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// settings map stand-in: writes land at the pointer held the cycle before the strobe
	assign reg_rdata = mem[reg_addr];
	always @(posedge ref_clk) begin
		if (reg_wr === 1'b1) begin
			mem[prev_addr] <= reg_wdata;
			wr_cnt++;
		end
		if (load_def === 1'b1) load_cnt++;
		if (spi_mode === 1'b1 && data_oe_n === 1'b0) spi_drv++;
		prev_addr <= reg_addr;
	end
	dual_format_control_port DUT (
		.REF_CLK_I(ref_clk),
		.RST_N_I(rst_n),
		.CTRL_BIT_CLK_I(bit_clk),
		.SERIAL_DATA_I(data_line),
		.SERIAL_DATA_O(data_o),
		.SERIAL_DATA_OE_N_O(data_oe_n),
		.ADDR_OR_SELECT_I(select_n),
		.REG_ADDR_O(reg_addr),
		.REG_WR_O(reg_wr),
		.REG_WDATA_O(reg_wdata),
		.REG_RDATA_I(reg_rdata),
		.PORT_EN_O(port_en),
		.LOAD_DEFAULTS_O(load_def),
		.CFG_PINS_LIVE_O(cfg_live),
		.SPI_MODE_O(spi_mode)
	);
	host_master_model host (
		.clk_i(ref_clk),
		.data_i(data_o),
		.data_oe_n_i(data_oe_n),
		.bit_clk_o(bit_clk),
		.data_line_o(data_line),
		.select_n_o(select_n)
	);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// two-wire write of the queued bytes after the pointer byte
	task automatic i2c_write(input logic [7:0] ptr);
		host.start();
		host.xfer_byte(dev_wr, 1'b1, rd, ack);
		chk({7'h00, ack}, 8'h00);
		host.xfer_byte(ptr, 1'b1, rd, ack);
		chk({7'h00, ack}, 8'h00);
		foreach (wq[i]) begin
			host.xfer_byte(wq[i], 1'b1, rd, ack);
			chk({7'h00, ack}, 8'h00);
		end
		host.stop();
	endtask
	task automatic spi_write();
		host.spi_begin();
		foreach (wq[i]) begin
			host.spi_byte(wq[i]);
		end
		host.spi_end();
	endtask
	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk);
		num_errors++;
		tally_and_finish();
	end
	initial begin
		rst_n = 1'b0;
		for (int i = 0; i < 32; i++) begin
			mem[i] = 8'ha0 + 8'(i);
		end
		repeat (5) @(posedge ref_clk);
		chk({3'h0, reg_addr}, 8'h00);
		chk({4'h0, port_en, cfg_live, spi_mode, data_oe_n}, 8'h05);
		rst_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
		// address pin is high, so the low-pin-zero address is someone else
		host.start();
		host.xfer_byte(8'h30, 1'b1, rd, ack);
		chk({7'h00, ack}, 8'h01);
		host.stop();
		chk(wr_cnt[7:0], 8'h00);
		// enable write (bit 1 of 02h) early, bursting on into 03h and 04h
		wq = {8'h02, 8'h55, 8'h66};
		i2c_write(8'h82);
		chk(mem[2], 8'h02);
		chk(mem[3], 8'h55);
		chk(mem[4], 8'h66);
		chk({4'h0, port_en, cfg_live, spi_mode, data_oe_n}, 8'h09);
		chk(load_cnt[7:0], 8'h01);
		// burst across the bank boundary stays at 08h
		wq = {8'h11, 8'h22, 8'h33};
		i2c_write(8'h87);
		chk(mem[7], 8'h11);
		chk(mem[8], 8'h33);
		chk(mem[9], 8'ha9);
		// reserved bits set, no auto-increment
		wq = {8'h44, 8'h45};
		i2c_write(8'h65);
		chk(mem[5], 8'h45);
		chk(mem[6], 8'ha6);
		chk({3'h0, reg_addr}, 8'h05);
		// pointer-only write, then a two byte read from 03h
		wq.delete();
		i2c_write(8'h83);
		host.start();
		host.xfer_byte(dev_rd, 1'b1, rd, ack);
		chk({7'h00, ack}, 8'h00);
		host.xfer_byte(8'hff, 1'b0, rd, ack);
		chk(rd, 8'h55);
		host.xfer_byte(8'hff, 1'b1, rd, ack);
		chk(rd, 8'h66);
		host.stop();
		chk({7'h00, data_oe_n}, 8'h01);
		// three-wire: falling select switches format, last byte wins without increment
		wq = {spi_hdr, 8'h0a, 8'h77, 8'h78};
		spi_write();
		chk({7'h00, spi_mode}, 8'h01);
		chk(mem[10], 8'h78);
		chk(mem[11], 8'hab);
		wq = {8'h32, 8'h0c, 8'h99};
		spi_write();
		chk(mem[12], 8'hac);
		wq = {spi_hdr, 8'h90, 8'h01, 8'h02};
		spi_write();
		chk(mem[16], 8'h01);
		chk(mem[17], 8'h02);
		// three-wire disable then enable again: only the fresh enable restores defaults
		wq = {spi_hdr, 8'h02, 8'h00, 8'h02};
		spi_write();
		chk({4'h0, port_en, cfg_live, spi_mode, data_oe_n}, 8'h0b);
		chk(load_cnt[7:0], 8'h02);
		chk(spi_drv[7:0], 8'h00);
		chk(wr_cnt[7:0], 8'h0e);
		// mid-run reset must bring every setting back, three-wire selection too
		rst_n <= 1'b0;
		repeat (5) @(posedge ref_clk);
		chk({3'h0, reg_addr}, 8'h00);
		chk({4'h0, port_en, cfg_live, spi_mode, data_oe_n}, 8'h05);
		tally_and_finish();
	end
endmodule
